// ### hdl/ssx_params.svh
// Purpose: Constants for the swap, skip, table read and xor execution block
// Assumes: 8-bit data path, 16-bit program words
// Notes: Operation codes are local to this block
`ifndef SSX_PARAMS_SVH
`define SSX_PARAMS_SVH
`define SSX_DATA_W 8
`define SSX_WORD_W 16
`define SSX_NIB_HI 7:4
`define SSX_NIB_LO 3:0
`define SSX_WORD_HI 15:8
`define SSX_WORD_LO 7:0
`define SSX_ZERO_BYTE 8'h00
`define SSX_ZERO_WORD 16'h0000
`define SSX_ZERO_ADDR 12'h000
`define SSX_SKIP_CYCLES 2'h2
`define SSX_PLAIN_CYCLES 2'h1
`endif

// ### hdl/ssx_pkg.sv
// Purpose: Types for the swap, skip, table read and xor execution block
// Assumes: Constants come from ssx_params.svh
// Notes: The testbench casts integers to operation codes, so their values are fixed
package ssx_pkg;
   typedef enum logic [3:0] {
      SSX_OP_NOP,
      SSX_OP_SWAP_W,
      SSX_OP_SKIP_NULL,
      SSX_OP_COPY_SKIP,
      SSX_OP_BIT_SKIP,
      SSX_OP_TBL_CUR,
      SSX_OP_TBL_LAST,
      SSX_OP_XOR_W,
      SSX_OP_XOR_MEM,
      SSX_OP_XOR_IMM
   } ssx_op_e;
   typedef enum logic [1:0] {
      SSX_ST_IDLE,
      SSX_ST_TABLE,
      SSX_ST_DUMMY
   } ssx_state_e;
endpackage

// ### hdl/ssx_alu.sv
// Purpose: Combinational result unit for swap, skip and xor operations
// Assumes: Operands are stable during the issue cycle
// Notes: Pure logic, no state
`timescale 1ns/1ps
`default_nettype none
`include "ssx_params.svh"
module ssx_alu
   import ssx_pkg::*;
(
   input wire ssx_op_e op_in,
   input wire logic [7:0] work_in,
   input wire logic [7:0] mem_in,
   input wire logic [7:0] imm_in,
   input wire logic [2:0] bit_sel_in,
   output logic [7:0] result_out,
   output logic skip_out,
   output logic null_out
);
   logic [7:0] bit_mask;
   genvar g;
   generate
      for (g = 0; g < `SSX_DATA_W; g++)
      begin : g_mask
         assign bit_mask[g] = (bit_sel_in == 3'(g));
      end
   endgenerate
   always_comb
   begin
      result_out = `SSX_ZERO_BYTE;
      skip_out = 1'b0;
      case (op_in)
         SSX_OP_SWAP_W: result_out = {mem_in[`SSX_NIB_LO], mem_in[`SSX_NIB_HI]};
         SSX_OP_SKIP_NULL: skip_out = (mem_in == `SSX_ZERO_BYTE);
         SSX_OP_COPY_SKIP:
         begin
            result_out = mem_in;
            skip_out = (mem_in == `SSX_ZERO_BYTE);
         end
         SSX_OP_BIT_SKIP: skip_out = ((mem_in & bit_mask) == `SSX_ZERO_BYTE);
         SSX_OP_XOR_W: result_out = work_in ^ mem_in;
         SSX_OP_XOR_MEM: result_out = work_in ^ mem_in;
         SSX_OP_XOR_IMM: result_out = work_in ^ imm_in;
         default: result_out = `SSX_ZERO_BYTE;
      endcase
      null_out = (result_out == `SSX_ZERO_BYTE);
   end
endmodule
`default_nettype wire

// ### hdl/ssx_exec.sv
// Purpose: Executes swap, skip, table read and xor instructions of an 8-bit core
// Assumes: Data byte is read combinationally from mem_data_in at issue
// Notes: Program word must be valid in the same cycle as the table fetch request
`timescale 1ns/1ps
`default_nettype none
`include "ssx_params.svh"
module ssx_exec
   import ssx_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int PAGE_W = 8
)
(
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic issue_in,
   input wire ssx_op_e op_in,
   input wire logic [7:0] mem_data_in,
   input wire logic [7:0] imm_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [7:0] table_pointer_in,
   input wire logic [ADDR_W-1:0] pc_in,
   input wire logic [15:0] prog_word_in,
   output logic [7:0] working_register_out,
   output logic null_flag_out,
   output logic [7:0] table_high_latch_out,
   output logic mem_we_out,
   output logic [7:0] mem_wdata_out,
   output logic prog_req_out,
   output logic [ADDR_W-1:0] prog_addr_out,
   output logic discard_out,
   output logic busy_out,
   output logic [1:0] cycles_out
);
   // The pointer fills the low byte, so a page narrower than the pointer cannot be served
   generate
      if (PAGE_W < $bits(table_pointer_in) || PAGE_W >= ADDR_W)
      begin : g_bad_page
         $error("ssx_exec: PAGE_W must be at least the pointer width and below ADDR_W");
      end
   endgenerate

   typedef struct packed {
      ssx_state_e st;
      logic [7:0] work;
      logic null_flag;
      logic [7:0] tbl_hi;
      logic mem_we;
      logic [7:0] mem_wdata;
      logic prog_req;
      logic [ADDR_W-1:0] prog_addr;
      logic discard;
      logic busy;
      logic [1:0] cycles;
   } ssx_state_s;

   ssx_state_s cur_ff;
   ssx_state_s nxt_cur;
   logic [7:0] alu_result;
   logic alu_skip;
   logic alu_null;
   logic [ADDR_W-1:0] page_base;

   ssx_alu u_alu (
      .op_in(op_in),
      .work_in(cur_ff.work),
      .mem_in(mem_data_in),
      .imm_in(imm_in),
      .bit_sel_in(bit_sel_in),
      .result_out(alu_result),
      .skip_out(alu_skip),
      .null_out(alu_null)
   );

   // Upper address bits select the page; the pointer supplies the low byte
   always_comb
   begin
      page_base = pc_in;
      page_base[PAGE_W-1:0] = '0;
   end

   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.mem_we = 1'b0;
      nxt_cur.prog_req = 1'b0;
      nxt_cur.discard = 1'b0;
      case (cur_ff.st)
         SSX_ST_IDLE:
         begin
            nxt_cur.busy = 1'b0;
            if (issue_in)
            begin
               nxt_cur.cycles = `SSX_PLAIN_CYCLES;
               case (op_in)
                  SSX_OP_SWAP_W: nxt_cur.work = alu_result;
                  SSX_OP_SKIP_NULL, SSX_OP_BIT_SKIP, SSX_OP_COPY_SKIP:
                  begin
                     if (op_in == SSX_OP_COPY_SKIP)
                     begin
                        nxt_cur.work = alu_result;
                     end
                     if (alu_skip)
                     begin
                        // Prefetched word is dropped and one dummy cycle follows
                        nxt_cur.discard = 1'b1;
                        nxt_cur.busy = 1'b1;
                        nxt_cur.cycles = `SSX_SKIP_CYCLES;
                        nxt_cur.st = SSX_ST_DUMMY;
                     end
                  end
                  SSX_OP_TBL_CUR, SSX_OP_TBL_LAST:
                  begin
                     nxt_cur.prog_req = 1'b1;
                     nxt_cur.busy = 1'b1;
                     nxt_cur.cycles = `SSX_SKIP_CYCLES;
                     nxt_cur.prog_addr = (op_in == SSX_OP_TBL_CUR) ? page_base : '1;
                     nxt_cur.prog_addr[`SSX_WORD_LO] = table_pointer_in;
                     nxt_cur.st = SSX_ST_TABLE;
                  end
                  SSX_OP_XOR_W, SSX_OP_XOR_IMM:
                  begin
                     nxt_cur.work = alu_result;
                     nxt_cur.null_flag = alu_null;
                  end
                  SSX_OP_XOR_MEM:
                  begin
                     nxt_cur.mem_we = 1'b1;
                     nxt_cur.mem_wdata = alu_result;
                     nxt_cur.null_flag = alu_null;
                  end
                  default: nxt_cur.cycles = `SSX_PLAIN_CYCLES;
               endcase
            end
         end
         SSX_ST_TABLE:
         begin
            nxt_cur.mem_we = 1'b1;
            nxt_cur.mem_wdata = prog_word_in[`SSX_WORD_LO];
            nxt_cur.tbl_hi = prog_word_in[`SSX_WORD_HI];
            nxt_cur.busy = 1'b0;
            nxt_cur.st = SSX_ST_IDLE;
         end
         SSX_ST_DUMMY:
         begin
            nxt_cur.busy = 1'b0;
            nxt_cur.st = SSX_ST_IDLE;
         end
         default: nxt_cur.st = SSX_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign working_register_out = cur_ff.work;
   assign null_flag_out = cur_ff.null_flag;
   assign table_high_latch_out = cur_ff.tbl_hi;
   assign mem_we_out = cur_ff.mem_we;
   assign mem_wdata_out = cur_ff.mem_wdata;
   assign prog_req_out = cur_ff.prog_req;
   assign prog_addr_out = cur_ff.prog_addr;
   assign discard_out = cur_ff.discard;
   assign busy_out = cur_ff.busy;
   assign cycles_out = cur_ff.cycles;

   swap_result_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_SWAP_W |=>
      working_register_out == {$past(mem_data_in[3:0]), $past(mem_data_in[7:4])})
      else $error("swap result wrong");
   swap_no_write_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_SWAP_W |=> !mem_we_out)
      else $error("swap wrote memory");
   skip_null_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_SKIP_NULL && mem_data_in == 8'h00 |=>
      discard_out && cycles_out == 2'h2 ##1 !busy_out)
      else $error("zero byte did not skip");
   copy_skip_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_COPY_SKIP |=>
      working_register_out == $past(mem_data_in) && discard_out == ($past(mem_data_in) == 8'h00))
      else $error("copy skip wrong");
   bit_skip_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_BIT_SKIP |=>
      discard_out == !$past(mem_data_in[bit_sel_in]))
      else $error("bit skip wrong");
   skip_dummy_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      $rose(discard_out) |-> busy_out ##1 (!discard_out && !busy_out))
      else $error("dummy cycle missing");
   table_cur_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_TBL_CUR |=>
      prog_req_out && prog_addr_out[7:0] == $past(table_pointer_in)
      ##1 mem_we_out && mem_wdata_out == $past(prog_word_in[7:0]))
      else $error("current page table read wrong");
   table_high_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      prog_req_out |=> table_high_latch_out == $past(prog_word_in[15:8]))
      else $error("table high latch wrong");
   table_last_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_TBL_LAST |=>
      prog_addr_out[ADDR_W-1:8] == '1)
      else $error("last page address wrong");
   xor_work_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_XOR_W |=>
      working_register_out == ($past(working_register_out) ^ $past(mem_data_in)))
      else $error("xor to working wrong");
   xor_mem_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_XOR_MEM |=>
      mem_we_out && mem_wdata_out == ($past(working_register_out) ^ $past(mem_data_in)))
      else $error("xor to memory wrong");
   xor_imm_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && op_in == SSX_OP_XOR_IMM |=>
      working_register_out == ($past(working_register_out) ^ $past(imm_in)))
      else $error("xor immediate wrong");
   xor_null_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && (op_in == SSX_OP_XOR_W || op_in == SSX_OP_XOR_IMM) |=>
      null_flag_out == (working_register_out == 8'h00))
      else $error("null flag wrong");
   flags_kept_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      issue_in && !busy_out && (op_in == SSX_OP_SWAP_W || op_in == SSX_OP_SKIP_NULL ||
      op_in == SSX_OP_COPY_SKIP || op_in == SSX_OP_BIT_SKIP || op_in == SSX_OP_TBL_CUR ||
      op_in == SSX_OP_TBL_LAST) |=> $stable(null_flag_out))
      else $error("flag changed");
endmodule
`default_nettype wire

// ### dv/swap_skip_table_xor_exec_tb.sv
// Purpose: Self-checking bench for the swap, skip, table read and xor execution block
// Assumes: Inputs change 1 ns after the rising edge; program word stands while the fetch request does
// Notes: A reference copy of working register, null flag and table latch tracks every operation
`timescale 1ns/1ps
`default_nettype none
module swap_skip_table_xor_exec_tb
   import ssx_pkg::*;
   ();
   logic core_clk_in;
   logic resetn_in;
   logic issue_in;
   ssx_op_e op_in;
   logic [7:0] mem_data_in;
   logic [7:0] imm_in;
   logic [2:0] bit_sel_in;
   logic [7:0] table_pointer_in;
   logic [11:0] pc_in;
   logic [15:0] prog_word_in;
   logic [7:0] working_register_out;
   logic null_flag_out;
   logic [7:0] table_high_latch_out;
   logic mem_we_out;
   logic [7:0] mem_wdata_out;
   logic prog_req_out;
   logic [11:0] prog_addr_out;
   logic discard_out;
   logic busy_out;
   logic [1:0] cycles_out;
   logic [7:0] w_m;
   logic n_m;
   logic [7:0] th_m;
   int n_mismatch;
   int tests_run;

   ssx_exec #(.ADDR_W(12), .PAGE_W(8)) i_dut (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in), .issue_in(issue_in), .op_in(op_in),
      .mem_data_in(mem_data_in), .imm_in(imm_in), .bit_sel_in(bit_sel_in),
      .table_pointer_in(table_pointer_in), .pc_in(pc_in), .prog_word_in(prog_word_in),
      .working_register_out(working_register_out), .null_flag_out(null_flag_out),
      .table_high_latch_out(table_high_latch_out), .mem_we_out(mem_we_out),
      .mem_wdata_out(mem_wdata_out), .prog_req_out(prog_req_out), .prog_addr_out(prog_addr_out),
      .discard_out(discard_out), .busy_out(busy_out), .cycles_out(cycles_out)
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic step();
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic run_op(input ssx_op_e op, input logic [7:0] m, input logic [7:0] imm,
                         input logic [2:0] bs, input logic [7:0] tp, input logic [11:0] pc);
      logic skip;
      logic tbl;
      logic [7:0] res;
      logic [15:0] pw;
      int k;
      k = 0;
      while (busy_out !== 1'b0)
      begin
         step();
         k++;
         if (k > 4)
         begin
            n_mismatch++;
            conclude();
         end
      end
      issue_in = 1'b1;
      op_in = op;
      mem_data_in = m;
      imm_in = imm;
      bit_sel_in = bs;
      table_pointer_in = tp;
      pc_in = pc;
      tbl = (op == SSX_OP_TBL_CUR) || (op == SSX_OP_TBL_LAST);
      skip = (op == SSX_OP_SKIP_NULL || op == SSX_OP_COPY_SKIP) ? (m == 8'h00) :
             (op == SSX_OP_BIT_SKIP) ? !m[bs] : 1'b0;
      res = w_m ^ m;
      step();
      // Request stays up: a busy design must ignore it, a plain op hands it to the next call
      if (skip || tbl)
      begin
         op_in = SSX_OP_XOR_IMM;
         imm_in = 8'hFF;
         mem_data_in = ~m;
      end
      case (op)
         SSX_OP_SWAP_W: w_m = {m[3:0], m[7:4]};
         SSX_OP_COPY_SKIP: w_m = m;
         SSX_OP_XOR_W: w_m = res;
         SSX_OP_XOR_IMM: w_m = w_m ^ imm;
         default: w_m = w_m;
      endcase
      if (op == SSX_OP_XOR_W || op == SSX_OP_XOR_IMM)
         n_m = (w_m == 8'h00);
      if (op == SSX_OP_XOR_MEM)
      begin
         n_m = (res == 8'h00);
         chk(16'(mem_wdata_out), 16'(res));
      end
      chk(16'(working_register_out), 16'(w_m));
      chk(16'(null_flag_out), 16'(n_m));
      chk(16'(mem_we_out), 16'(op == SSX_OP_XOR_MEM));
      chk(16'(prog_req_out), 16'(tbl));
      if (tbl)
      begin
         chk(16'(prog_addr_out), 16'(op == SSX_OP_TBL_CUR ? {pc[11:8], tp} : {4'hF, tp}));
         pw = 16'($urandom);
         prog_word_in = pw;
         step();
         prog_word_in = ~pw;
         th_m = pw[15:8];
         chk(16'(mem_we_out), 16'h0001);
         chk(16'(mem_wdata_out), 16'(pw[7:0]));
         chk(16'(busy_out), 16'h0000);
         chk(16'(null_flag_out), 16'(n_m));
      end
      else
      begin
         chk(16'(discard_out), 16'(skip));
         chk(16'(busy_out), 16'(skip));
         chk(16'(cycles_out), skip ? 16'h0002 : 16'h0001);
         if (skip)
         begin
            step();
            chk(16'(busy_out), 16'h0000);
            chk(16'(discard_out), 16'h0000);
            chk(16'(working_register_out), 16'(w_m));
            chk(16'(mem_we_out), 16'h0000);
         end
      end
      chk(16'(table_high_latch_out), 16'(th_m));
   endtask

   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   initial
   begin
      resetn_in = 1'b0;
      issue_in = 1'b0;
      op_in = SSX_OP_NOP;
      mem_data_in = 8'h00;
      imm_in = 8'h00;
      bit_sel_in = 3'h0;
      table_pointer_in = 8'h00;
      pc_in = 12'h000;
      prog_word_in = 16'h0000;
      w_m = 8'h00;
      n_m = 1'b0;
      th_m = 8'h00;
      n_mismatch = 0;
      tests_run = 0;
      void'($urandom(32'h1da6_2d58));
      repeat (6) @(posedge core_clk_in);
      #1;
      resetn_in = 1'b1;
      // Every operation except NOP once with a zero byte, then the bit skip edge cases
      for (int i = 1; i <= 9; i++)
         run_op(ssx_op_e'(i), 8'h00, 8'h5A, 3'h7, 8'hFF, 12'hABC);
      run_op(SSX_OP_BIT_SKIP, 8'hFE, 8'h00, 3'h0, 8'h00, 12'h000);
      run_op(SSX_OP_BIT_SKIP, 8'h01, 8'h00, 3'h0, 8'h00, 12'h000);
      run_op(SSX_OP_BIT_SKIP, 8'h7F, 8'h00, 3'h7, 8'h00, 12'h000);
      run_op(SSX_OP_XOR_IMM, 8'h00, w_m, 3'h0, 8'h00, 12'h000);
      for (int i = 0; i < 400; i++)
      begin
         logic [7:0] m;
         case ($urandom_range(3))
            0: m = 8'h00;
            1: m = w_m;
            default: m = 8'($urandom);
         endcase
         run_op(ssx_op_e'(1 + $urandom_range(8)), m, 8'($urandom), 3'($urandom),
                8'($urandom), 12'($urandom));
      end
      conclude();
   end
endmodule
`default_nettype wire
